// *** verilog/vtn_defs.svh ***
// Constants for the vicinity tag network command interpreter.
// Included by the design; definitions only.
`ifndef VTN_DEFS_SVH
`define VTN_DEFS_SVH
`define VTN_CMD_QUIET 8'h02
`define VTN_CMD_SELECT 8'h25
`define VTN_CMD_READY 8'h26
`define VTN_CMD_SYSINFO 8'h2b
// Flag positions count from bit 0, one below the usual one-based flag numbering.
`define VTN_FLAG_ADDR 5
`define VTN_FLAG_SEL 4
`define VTN_RSP_OK 8'h00
`define VTN_RSP_ERR 8'h01
`define VTN_INFO_FLAGS 8'h0f
`define VTN_BLOCK_COUNT 8'h00
`define VTN_BLOCK_SIZE 8'h07
`define VTN_ERR_NOT_SUPPORTED 8'h0f
`define VTN_CRC_PRESET 16'hffff
`define VTN_CRC_POLY_REV 16'h8408
`define VTN_CRC_RESIDUE 16'hf0b8
`endif

// *** verilog/vtn_pkg.sv ***
// Types shared by the vicinity tag network command interpreter.
// Assumes vtn_defs.svh is on the include path.
package vtn_pkg;
    typedef enum logic [1:0] {
        VTN_READY = 2'b00,
        VTN_QUIET = 2'b01,
        VTN_SELECTED = 2'b10
    } vtn_tag_state_t;

    typedef enum logic [1:0] {
        VTN_IDLE = 2'b00,
        VTN_RECV = 2'b01,
        VTN_EXEC = 2'b10,
        VTN_SEND = 2'b11
    } vtn_phase_t;

    typedef struct packed {
        logic sof;
        logic valid;
        logic [7:0] data;
        logic eof;
    } vtn_rx_t;

    typedef struct packed {
        logic sof;
        logic valid;
        logic [7:0] data;
        logic eof;
    } vtn_tx_t;

    typedef struct packed {
        vtn_tag_state_t tag_state;
        vtn_phase_t phase;
        logic [15:0] crc;
        logic [4:0] count;
        logic [7:0] flags;
        logic [7:0] cmd;
        logic uid_match;
        logic overflow;
        logic [4:0] tx_index;
        logic [4:0] tx_last;
        logic err;
        vtn_tx_t tx;
    } vtn_state_t;
endpackage

// *** verilog/vtn_core.sv ***
// Network command interpreter of a passive vicinity tag, run on the carrier clock.
// Assumes a framer supplies decoded bytes with SOF/EOF marks and encodes bytes it emits.
`timescale 1ns/10ps
`include "vtn_defs.svh"
module vtn_core
    import vtn_pkg::*;
#(
    parameter logic [63:0] UID = 64'h0123456789abcdef,
    parameter logic [7:0] DSFID = 8'h00,
    parameter logic [7:0] AFI = 8'h00,
    // Die revision value is arbitrary.
    parameter logic [7:0] DIE_REVISION = 8'h5a
)
(
    input wire logic clk,
    input wire logic rst,
    input wire vtn_rx_t rx,
    output vtn_tx_t tx,
    output vtn_tag_state_t tag_state
);

    vtn_state_t s_reg;
    vtn_state_t s_next;

    // Reflected CRC step; bit 0 of the data goes in first, matching the air order.
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ d[i])
                r = (r >> 1) ^ `VTN_CRC_POLY_REV;
            else
                r = r >> 1;
        end
        return r;
    endfunction

    function automatic logic [7:0] uid_byte(input logic [4:0] idx);
        return UID[8 * idx[2:0] +: 8];
    endfunction

    // Response byte at a position; the CRC bytes follow the last data byte.
    function automatic logic [7:0] rsp_byte(input vtn_state_t s);
        logic [7:0] b;
        b = 8'h00;
        if (s.err)
        begin
            case (s.tx_index)
                5'd0: b = `VTN_RSP_ERR;
                default: b = `VTN_ERR_NOT_SUPPORTED;
            endcase
        end
        else if (s.cmd != `VTN_CMD_SYSINFO)
            b = `VTN_RSP_OK;
        else
        begin
            case (s.tx_index)
                5'd0: b = `VTN_RSP_OK;
                5'd1: b = `VTN_INFO_FLAGS;
                5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7, 5'd8, 5'd9:
                    b = uid_byte(s.tx_index - 5'd2);
                5'd10: b = DSFID;
                5'd11: b = AFI;
                5'd12: b = `VTN_BLOCK_COUNT;
                5'd13: b = `VTN_BLOCK_SIZE;
                default: b = DIE_REVISION;
            endcase
        end
        return b;
    endfunction

    logic addr_mode;
    logic sel_mode;
    logic frame_ok;
    logic accept;
    logic [7:0] out_byte;

    always_comb
    begin
        addr_mode = s_reg.flags[`VTN_FLAG_ADDR];
        sel_mode = s_reg.flags[`VTN_FLAG_SEL];
        // Frame length: flags, command, identifier if addressed, two CRC bytes.
        frame_ok = (s_reg.crc == `VTN_CRC_RESIDUE) && !s_reg.overflow &&
            (s_reg.count == (addr_mode ? 5'd12 : 5'd4)) &&
            !(addr_mode && sel_mode) &&
            (!addr_mode || s_reg.uid_match);
        // Quiet tags only answer addressed requests; select-only needs selected.
        accept = frame_ok &&
            (!sel_mode || s_reg.tag_state == VTN_SELECTED) &&
            (s_reg.tag_state != VTN_QUIET || addr_mode);
        out_byte = 8'h00;
        if (s_reg.tx_index == s_reg.tx_last)
            out_byte = ~s_reg.crc[7:0];
        else if (s_reg.tx_index > s_reg.tx_last)
            out_byte = ~s_reg.crc[15:8];
        else
            out_byte = rsp_byte(s_reg);
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.tx = '0;
        case (s_reg.phase)
            VTN_IDLE:
            begin
                if (rx.sof)
                begin
                    s_next.phase = VTN_RECV;
                    s_next.crc = `VTN_CRC_PRESET;
                    s_next.count = 5'd0;
                    s_next.uid_match = 1'b1;
                    s_next.overflow = 1'b0;
                end
            end
            VTN_RECV:
            begin
                if (rx.valid)
                begin
                    s_next.crc = crc_byte(s_reg.crc, rx.data);
                    if (s_reg.count == 5'd31)
                        s_next.overflow = 1'b1;
                    else
                        s_next.count = s_reg.count + 5'd1;
                    if (s_reg.count == 5'd0)
                        s_next.flags = rx.data;
                    if (s_reg.count == 5'd1)
                        s_next.cmd = rx.data;
                    // The identifier arrives low byte first after the command.
                    if (s_reg.count >= 5'd2 && s_reg.count <= 5'd9 &&
                        rx.data != uid_byte(s_reg.count - 5'd2))
                        s_next.uid_match = 1'b0;
                end
                if (rx.sof)
                begin
                    s_next.crc = `VTN_CRC_PRESET;
                    s_next.count = 5'd0;
                    s_next.uid_match = 1'b1;
                    s_next.overflow = 1'b0;
                end
                else if (rx.eof)
                    s_next.phase = VTN_EXEC;
            end
            VTN_EXEC:
            begin
                s_next.phase = VTN_IDLE;
                s_next.err = 1'b0;
                s_next.tx_index = 5'd0;
                s_next.crc = `VTN_CRC_PRESET;
                if (accept)
                begin
                    case (s_reg.cmd)
                        `VTN_CMD_QUIET:
                        begin
                            // Only addressed form is meaningful.
                            if (addr_mode)
                                s_next.tag_state = VTN_QUIET;
                        end
                        `VTN_CMD_SELECT:
                        begin
                            if (addr_mode)
                            begin
                                s_next.tag_state = VTN_SELECTED;
                                s_next.tx_last = 5'd1;
                                s_next.phase = VTN_SEND;
                            end
                        end
                        `VTN_CMD_READY:
                        begin
                            s_next.tag_state = VTN_READY;
                            s_next.tx_last = 5'd1;
                            s_next.phase = VTN_SEND;
                        end
                        `VTN_CMD_SYSINFO:
                        begin
                            s_next.tx_last = 5'd15;
                            s_next.phase = VTN_SEND;
                        end
                        default:
                        begin
                            s_next.phase = VTN_IDLE;
                        end
                    endcase
                end
                else if (frame_ok && s_reg.cmd == `VTN_CMD_SELECT &&
                    s_reg.tag_state == VTN_SELECTED)
                begin
                    // Frame was good and named this tag or none; a selected tag always accepts that, so this is never reached.
                end
                // A selected tag hearing a select for someone else drops out silently.
                if (s_reg.cmd == `VTN_CMD_SELECT && addr_mode && !sel_mode &&
                    s_reg.tag_state == VTN_SELECTED &&
                    (s_reg.crc == `VTN_CRC_RESIDUE) && !s_reg.overflow &&
                    s_reg.count == 5'd12 && !s_reg.uid_match)
                    s_next.tag_state = VTN_READY;
            end
            VTN_SEND:
            begin
                s_next.tx.valid = 1'b1;
                s_next.tx.sof = (s_reg.tx_index == 5'd0);
                s_next.tx.data = out_byte;
                s_next.tx.eof = (s_reg.tx_index == s_reg.tx_last + 5'd1);
                if (s_reg.tx_index < s_reg.tx_last)
                    s_next.crc = crc_byte(s_reg.crc, out_byte);
                if (s_reg.tx_index == s_reg.tx_last + 5'd1)
                    s_next.phase = VTN_IDLE;
                else
                    s_next.tx_index = s_reg.tx_index + 5'd1;
            end
            default:
            begin
                s_next.phase = VTN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.crc <= `VTN_CRC_PRESET;
        end
        else
            s_reg <= s_next;
    end

    assign tx = s_reg.tx;
    assign tag_state = s_reg.tag_state;

    property p_quiet_silent;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && accept && s_reg.cmd == `VTN_CMD_QUIET && addr_mode)
            |=> (tag_state == VTN_QUIET) ##0 !tx.valid [*3];
    endproperty
    a_quiet_silent: assert property (p_quiet_silent) else $error("quiet answered");

    property p_select_resp;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && accept && s_reg.cmd == `VTN_CMD_SELECT && addr_mode)
            |=> tag_state == VTN_SELECTED ##1 (tx.sof && tx.data == 8'h00);
    endproperty
    a_select_resp: assert property (p_select_resp) else $error("select not answered");

    property p_deselect;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && s_reg.tag_state == VTN_SELECTED &&
            s_reg.cmd == `VTN_CMD_SELECT && frame_ok == 1'b0 && s_reg.count == 5'd12 &&
            !s_reg.uid_match && addr_mode && !sel_mode &&
            s_reg.crc == `VTN_CRC_RESIDUE && !s_reg.overflow)
            |=> tag_state == VTN_READY && s_reg.phase == VTN_IDLE;
    endproperty
    a_deselect: assert property (p_deselect) else $error("no fallback to ready");

    property p_ready_resp;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && accept && s_reg.cmd == `VTN_CMD_READY)
            |=> tag_state == VTN_READY ##1 tx.sof;
    endproperty
    a_ready_resp: assert property (p_ready_resp) else $error("ready not answered");

    property p_quiet_addr;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && s_reg.tag_state == VTN_QUIET && !addr_mode)
            |=> s_reg.phase == VTN_IDLE && tag_state == VTN_QUIET;
    endproperty
    a_quiet_addr: assert property (p_quiet_addr) else $error("quiet obeyed unaddressed");

    property p_error_code;
        @(posedge clk) disable iff (rst)
        (tx.valid && tx.sof && s_reg.err) |-> tx.data == 8'h01;
    endproperty
    a_error_code: assert property (p_error_code) else $error("bad error flags");

    property p_unknown;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && !(s_reg.cmd inside {8'h02, 8'h25, 8'h26, 8'h2b}))
            |=> s_reg.phase == VTN_IDLE ##1 !tx.valid;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown command answered");

    property p_sysinfo_len;
        @(posedge clk) disable iff (rst)
        (tx.sof && s_reg.cmd == `VTN_CMD_SYSINFO && !s_reg.err)
            |-> ##1 tx.data == 8'h0f ##12 tx.data == 8'h07 ##1 tx.data == DIE_REVISION
                ##2 tx.eof;
    endproperty
    a_sysinfo_len: assert property (p_sysinfo_len) else $error("sysinfo layout");

    property p_bad_crc;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && s_reg.crc != `VTN_CRC_RESIDUE)
            |=> s_reg.phase == VTN_IDLE && $stable(tag_state);
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad CRC acted on");

    property p_both_flags;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && addr_mode && sel_mode)
            |=> s_reg.phase == VTN_IDLE && $stable(tag_state);
    endproperty
    a_both_flags: assert property (p_both_flags) else $error("flag pair acted on");

    property p_select_only;
        @(posedge clk) disable iff (rst)
        (s_reg.phase == VTN_EXEC && sel_mode && s_reg.tag_state != VTN_SELECTED)
            |=> s_reg.phase == VTN_IDLE && $stable(tag_state);
    endproperty
    a_select_only: assert property (p_select_only) else $error("select-only obeyed");

    property p_frame_end;
        @(posedge clk) disable iff (rst)
        (tx.valid && tx.eof) |=> !tx.valid;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("byte after frame end");

endmodule

// *** testbench/vtn_reader.sv ***
// Reader-side model that frames request bytes for the tag interpreter.
// Assumes one bench process calls send_frame at a time, on the carrier clock.
`timescale 1ns/10ps
module vtn_reader
    import vtn_pkg::*;
(
    input wire logic clk,
    output vtn_rx_t rx
);
    logic [7:0] last_data;

    initial
    begin
        rx = '0;
        last_data = 8'h00;
    end

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return c;
    endfunction

    // The data bus shows the inverse of the last byte when idle, so a stale byte never matches.
    task automatic drive(input logic s, input logic v, input logic [7:0] d, input logic e);
        @(negedge clk);
        rx.sof = s;
        rx.valid = v;
        rx.eof = e;
        rx.data = v ? d : ~last_data;
        if (v)
            last_data = d;
    endtask

    task automatic send_frame(input logic [7:0] b[$], input logic corrupt);
        logic [15:0] c;
        c = ~crc16(b);
        if (corrupt)
            c[3] = ~c[3];
        drive(1'b1, 1'b0, 8'h00, 1'b0);
        foreach (b[i])
            drive(1'b0, 1'b1, b[i], 1'b0);
        drive(1'b0, 1'b1, c[7:0], 1'b0);
        drive(1'b0, 1'b1, c[15:8], 1'b0);
        drive(1'b0, 1'b0, 8'h00, 1'b1);
        drive(1'b0, 1'b0, 8'h00, 1'b0);
    endtask
endmodule

// *** testbench/vtn_core_test.sv ***
// Self-checking bench for the tag command interpreter.
// Assumes the reader model drives requests on falling edges; responses are queued expectations.
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end
module vtn_core_test
    import vtn_pkg::*;
;
    localparam logic [63:0] UID = 64'h1f2e3d4c5b6a7988;
    localparam logic [7:0] DSFID = 8'h3c;
    localparam logic [7:0] AFI = 8'h9d;
    // Revision value is arbitrary.
    localparam logic [7:0] REV = 8'h6b;
    logic clk;
    logic rst;
    vtn_rx_t rx;
    vtn_tx_t tx;
    vtn_tag_state_t tag_state;
    integer num_errors;
    integer checks;
    vtn_tx_t exp_q[$];
    vtn_tx_t e;
    logic [7:0] c;

    vtn_core #(.UID(UID), .DSFID(DSFID), .AFI(AFI), .DIE_REVISION(REV)) dut (
        .clk(clk),
        .rst(rst),
        .rx(rx),
        .tx(tx),
        .tag_state(tag_state)
    );

    vtn_reader rdr (
        .clk(clk),
        .rx(rx)
    );

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic expect_rsp(input logic [7:0] b[$]);
        logic [15:0] k;
        k = ~rdr.crc16(b);
        b.push_back(k[7:0]);
        b.push_back(k[15:8]);
        foreach (b[i])
            exp_q.push_back('{i == 0, 1'b1, b[i], i == b.size() - 1});
    endtask

    task automatic expect_si();
        logic [7:0] b[$];
        b = '{8'h00, 8'h0f};
        for (int i = 0; i < 8; i++)
            b.push_back(UID[8*i +: 8]);
        b = {b, DSFID, AFI, 8'h00, 8'h07, REV};
        expect_rsp(b);
    endtask

    // Low flag bits (rate and subcarrier) are random; they must not change the outcome.
    task automatic req(input logic [7:0] fl, input logic [7:0] cmd, input logic [63:0] id,
                       input logic bad, input vtn_tag_state_t st);
        logic [7:0] b[$];
        b = '{fl | 8'($urandom % 4), cmd};
        if (fl[5])
            for (int i = 0; i < 8; i++)
                b.push_back(id[8*i +: 8]);
        rdr.send_frame(b, bad);
        repeat (24) @(negedge clk);
        `CHK("tag state", st, tag_state)
        `CHK("missing bytes", 0, exp_q.size())
    endtask

    always @(posedge clk)
    begin
        if (tx.valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK("silent tag", 1'b0, tx.valid)
            else
            begin
                e = exp_q.pop_front();
                `CHK("response byte", e, tx)
            end
        end
    end

    initial
    begin
        #(25ns * 5000);
        num_errors++;
        conclude();
    end

    initial
    begin
        rst = 1'b1;
        num_errors = 0;
        checks = 0;
        void'($urandom(24));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        `CHK("idle output", '0, tx)
        `CHK("reset state", VTN_READY, tag_state)
        expect_rsp('{8'h00});
        req(8'h20, 8'h25, UID, 1'b0, VTN_SELECTED);
        expect_si();
        req(8'h00, 8'h2b, UID, 1'b0, VTN_SELECTED);
        expect_si();
        req(8'h10, 8'h2b, UID, 1'b0, VTN_SELECTED);
        expect_si();
        req(8'h20, 8'h2b, UID, 1'b0, VTN_SELECTED);
        req(8'h20, 8'h25, UID ^ 64'h0100, 1'b0, VTN_READY);
        req(8'h10, 8'h2b, UID, 1'b0, VTN_READY);
        req(8'h20, 8'h02, UID, 1'b0, VTN_QUIET);
        req(8'h00, 8'h2b, UID, 1'b0, VTN_QUIET);
        req(8'h00, 8'h26, UID, 1'b0, VTN_QUIET);
        expect_si();
        req(8'h20, 8'h2b, UID, 1'b0, VTN_QUIET);
        req(8'h20, 8'h26, UID, 1'b1, VTN_QUIET);
        expect_rsp('{8'h00});
        req(8'h20, 8'h26, UID, 1'b0, VTN_READY);
        req(8'h30, 8'h25, UID, 1'b0, VTN_READY);
        for (int n = 0; n < 6; n++)
        begin
            c = 8'($urandom);
            if (c inside {8'h01, 8'h02, 8'h25, 8'h26, 8'h2b})
                c = 8'h20;
            req(8'h20, c, UID, 1'b0, VTN_READY);
        end
        expect_rsp('{8'h00});
        req(8'h20, 8'h25, UID, 1'b0, VTN_SELECTED);
        expect_rsp('{8'h00});
        req(8'h00, 8'h26, UID, 1'b0, VTN_READY);
        conclude();
    end
endmodule
